// ==== core/channel_playback_command_decoder.sv ====
/*
  Per-channel playback command decoder with an AXI4-Lite register slave.
  Assumes the audio datapath pulses phrase_end on this clock when a phrase ends.
*/
// Register access over AXI4-Lite and the register addresses were left to the implementer.
// Function
// - Launch: opcode 0100, phrase bits 9-8, channel number; byte two phrase bits 7-0.
// - Launch reaches phrases 0 to 1023 only; higher ones need extended launch.
// - Start, opcode 0101 with mask, plays each masked channel's selected phrase.
// - Masked commands with an all-zero mask are discarded without effect.
// - Stop, opcode 0110, halts masked channels; ready and busy_n go high.
// - Silence, opcode 0111 with mask and length byte, queues a silent gap.
// - Silence lasts (length plus one) times 4 ms; length must be at least 04h.
// - Silence segments never repeat; repeat applies to phrases only.
// - Set-repeat, opcode 1000, replays masked channel phrase until cleared or stopped.
// - Clear-repeat, opcode 1001, accepted anytime, cancels repeat; ready returns high.
// - Volume, opcode 1010, accepted anytime, sets seven-bit code on masked channels.
// - Volume byte two: bit 7 zero, bits 6-5 low code bits, bits 4-0 upper.
// - Volumes return to initial value on reset and accepted power-down.
// - Clear-repeat and volume commands ignore every channel ready state.
// - Phrase-select stores a phrase per channel; start later plays it.
// - Several mask bits on volume write the same code to each channel.
// - Low two volume bits at zero give a coarse 32-step scale.
`timescale 1ns/1ps
module channel_playback_command_decoder #(
  parameter logic [17:0] SILENCE_UNIT_CYCLES = 18'(playback_cmd_pkg::SILENCE_UNIT_CYC)
) (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    cmd_sclk,
  input  wire logic                    cmd_cs_n,
  input  wire logic                    cmd_si,
  input  wire logic [3:0]              phrase_end,
  output logic      [3:0]              channel_cmd_ready,
  output logic      [3:0]              channel_busy_n,
  output logic      [3:0]              launch_phrase_cmd_start,
  output logic      [3:0]              launch_phrase_cmd_stop,
  output logic      [3:0][9:0]         launch_phrase_cmd_index,
  output logic      [3:0][6:0]         channel_volume,
  output logic                         power_down_req,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic      [1:0]              s_axi_bresp,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic      [31:0]             s_axi_rdata,
  output logic      [1:0]              s_axi_rresp
);
  import playback_cmd_pkg::*;

  typedef struct packed {
    logic                   waiting;
    logic [7:0]             first;
    logic                   cmd_hold;
    chan_kind_t [3:0]       kind;
    logic [3:0]             pend;
    chan_kind_t [3:0]       pend_kind;
    logic [3:0][9:0]        pend_phrase;
    logic [3:0][7:0]        pend_len;
    logic [3:0][9:0]        sel_phrase;
    logic [3:0]             rpt;
    logic [3:0][8:0]        units;
    logic [3:0][17:0]       sub;
    logic [3:0][6:0]        volume;
    logic [3:0]             start_p;
    logic [3:0]             stop_p;
    logic [3:0][9:0]        index;
    logic                   pd_p;
    logic                   aw_got;
    logic                   w_got;
    logic [7:0]             awaddr;
    logic [31:0]            wdata;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } state_t;

  state_t     st;
  state_t     next_st;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       rx_fstart;
  logic [3:0] acc_queue;
  logic [3:0] acc_stop;
  logic [3:0] acc_clr;
  logic [3:0] acc_vol;
  logic       zero_mask_cmd;
  logic [6:0] vol_code;
  logic [3:0] ready;

  function automatic logic [6:0] decode_volume(input logic [7:0] b);
    return {b[VOL_LOW_LSB-1:0], b[VOL_LOW_LSB+1:VOL_LOW_LSB]};
  endfunction : decode_volume

  function automatic logic is_two_byte(input logic [3:0] op);
    return (op == OP_LAUNCH) || (op == OP_SELECT) || (op == OP_SILENCE) || (op == OP_VOLUME);
  endfunction : is_two_byte

  serial_byte_rx u_rx (
    .clk         (clk),
    .rstn        (rstn),
    .sclk_pin    (cmd_sclk),
    .cs_n_pin    (cmd_cs_n),
    .si_pin      (cmd_si),
    .byte_valid  (rx_valid),
    .byte_data   (rx_data),
    .frame_start (rx_fstart)
  );

  // Ready low while queued or repeating
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ready[i] = ~st.pend[i] & ~(st.rpt[i] & (st.kind[i] != K_IDLE));
    end
  end

  always_comb begin
    logic       exec;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [3:0] op;
    logic [3:0] mask;
    logic [1:0] ch;
    logic       wr_fire;
    logic [7:0] waddr;
    logic [31:0] wdat;
    exec          = 1'b0;
    b1            = 8'h00;
    b2            = 8'h00;
    wr_fire       = 1'b0;
    waddr         = 8'h00;
    wdat          = 32'h0000_0000;
    op            = 4'h0;
    mask          = 4'h0;
    ch            = 2'd0;
    next_st       = st;
    next_st.start_p = 4'h0;
    next_st.stop_p  = 4'h0;
    next_st.pd_p    = 1'b0;
    acc_queue     = 4'h0;
    acc_stop      = 4'h0;
    acc_clr       = 4'h0;
    acc_vol       = 4'h0;
    zero_mask_cmd = 1'b0;
    // Channel progress
    for (int i = 0; i < NUM_CH; i++) begin
      unique case (st.kind[i])
        K_IDLE: begin
          if (st.pend[i]) begin
            next_st.kind[i] = st.pend_kind[i];
            next_st.pend[i] = 1'b0;
            if (st.pend_kind[i] == K_PHRASE) begin
              next_st.start_p[i] = 1'b1;
              next_st.index[i]   = st.pend_phrase[i];
            end else begin
              next_st.units[i] = {1'b0, st.pend_len[i]} + 9'd1;
              next_st.sub[i]   = SILENCE_UNIT_CYCLES - 18'd1;
            end
          end
        end
        K_PHRASE: begin
          if (phrase_end[i]) begin
            if (st.rpt[i]) begin
              next_st.start_p[i] = 1'b1;
            end else begin
              next_st.kind[i] = K_IDLE;
            end
          end
        end
        K_SILENCE: begin
          if (st.sub[i] == 18'd0) begin
            if (st.units[i] == 9'd1) begin
              next_st.kind[i] = K_IDLE;
            end else begin
              next_st.units[i] = st.units[i] - 9'd1;
              next_st.sub[i]   = SILENCE_UNIT_CYCLES - 18'd1;
            end
          end else begin
            next_st.sub[i] = st.sub[i] - 18'd1;
          end
        end
        default: next_st.kind[i] = K_IDLE;
      endcase
    end
    // Byte assembly
    if (rx_fstart) begin
      next_st.waiting = 1'b0;
    end
    if (rx_valid && !st.cmd_hold) begin
      if (!st.waiting && !rx_fstart && is_two_byte(rx_data[7:OP_LSB])) begin
        next_st.waiting = 1'b1;
        next_st.first   = rx_data;
      end else if (!st.waiting || !rx_fstart) begin
        exec            = 1'b1;
        b1              = st.waiting ? st.first : rx_data;
        b2              = rx_data;
        next_st.waiting = 1'b0;
      end
    end
    op       = b1[7:OP_LSB];
    mask     = b1[3:0];
    ch       = b1[1:0];
    vol_code = decode_volume(b2);
    if (exec) begin
      if (b1 == POWER_DOWN_BYTE) begin
        if (&channel_busy_n) begin
          next_st.volume = {NUM_CH{VOL_INIT}};
          next_st.pd_p   = 1'b1;
        end
      end else if (op == OP_LAUNCH || op == OP_SELECT) begin
        if (ready[ch]) begin
          if (op == OP_LAUNCH) begin
            acc_queue[ch]           = 1'b1;
            next_st.pend[ch]        = 1'b1;
            next_st.pend_kind[ch]   = K_PHRASE;
            next_st.pend_phrase[ch] = {b1[PHRASE_HI_LSB+1:PHRASE_HI_LSB], b2};
          end else begin
            next_st.sel_phrase[ch] = {b1[PHRASE_HI_LSB+1:PHRASE_HI_LSB], b2};
          end
        end
      end else if (mask == 4'h0) begin
        zero_mask_cmd = (op >= OP_START) && (op <= OP_VOLUME);
      end else begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (mask[i]) begin
            unique case (op)
              OP_START, OP_SILENCE: begin
                if (ready[i]) begin
                  acc_queue[i]           = 1'b1;
                  next_st.pend[i]        = 1'b1;
                  next_st.pend_kind[i]   = (op == OP_START) ? K_PHRASE : K_SILENCE;
                  next_st.pend_phrase[i] = st.sel_phrase[i];
                  next_st.pend_len[i]    = b2;
                end
              end
              OP_SET_REPEAT: begin
                if (ready[i]) begin
                  // Idle channel only arms repeat
                  acc_queue[i]   = (next_st.kind[i] != K_IDLE);
                  next_st.rpt[i] = 1'b1;
                end
              end
              OP_STOP: begin
                acc_stop[i]        = 1'b1;
                next_st.kind[i]    = K_IDLE;
                next_st.pend[i]    = 1'b0;
                next_st.rpt[i]     = 1'b0;
                next_st.start_p[i] = 1'b0;
                next_st.stop_p[i]  = 1'b1;
              end
              OP_CLEAR_REPEAT: begin
                acc_clr[i]     = 1'b1;
                next_st.rpt[i] = 1'b0;
              end
              OP_VOLUME: begin
                acc_vol[i]        = 1'b1;
                next_st.volume[i] = vol_code;
              end
              default: ;
            endcase
          end
        end
      end
    end
    // AXI4-Lite write channel
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
    end
    wr_fire = (st.aw_got || (s_axi_awvalid && s_axi_awready)) && (st.w_got || (s_axi_wvalid && s_axi_wready));
    waddr   = st.aw_got ? st.awaddr : s_axi_awaddr;
    wdat    = st.w_got ? st.wdata : s_axi_wdata;
    if (wr_fire) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = RESP_OKAY;
      if (waddr == REG_CONTROL) begin
        if (s_axi_wstrb[0]) begin
          next_st.cmd_hold = wdat[CONTROL_HOLD_BIT];
        end
      end else if (waddr != REG_STATUS && waddr != REG_VOLUME) begin
        next_st.bresp = RESP_SLVERR;
      end
    end else if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // AXI4-Lite read channel
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      next_st.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        REG_STATUS: begin
          next_st.rdata[3:0]                             = ready;
          next_st.rdata[STATUS_BUSY_LSB+3:STATUS_BUSY_LSB] = channel_busy_n;
          next_st.rdata[STATUS_RPT_LSB+3:STATUS_RPT_LSB]   = st.rpt;
        end
        REG_CONTROL: next_st.rdata[CONTROL_HOLD_BIT] = st.cmd_hold;
        REG_VOLUME: begin
          for (int i = 0; i < NUM_CH; i++) begin
            next_st.rdata[8*i +: 8] = {1'b0, st.volume[i]};
          end
        end
        default: next_st.rresp = RESP_SLVERR;
      endcase
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      channel_busy_n[i] = (st.kind[i] == K_IDLE) & ~st.pend[i];
    end
  end

  assign channel_cmd_ready = ready;
  assign launch_phrase_cmd_start        = st.start_p;
  assign launch_phrase_cmd_stop         = st.stop_p;
  assign launch_phrase_cmd_index        = st.index;
  assign channel_volume    = st.volume;
  assign power_down_req    = st.pd_p;
  assign s_axi_awready     = ~st.aw_got & ~st.bvalid;
  assign s_axi_wready      = ~st.w_got & ~st.bvalid;
  assign s_axi_bvalid      = st.bvalid;
  assign s_axi_bresp       = st.bresp;
  assign s_axi_arready     = ~st.rvalid;
  assign s_axi_rvalid      = st.rvalid;
  assign s_axi_rdata       = st.rdata;
  assign s_axi_rresp       = st.rresp;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
    sequence s_load_phrase;
      st.kind[g] == K_IDLE && st.pend[g] && st.pend_kind[g] == K_PHRASE && !acc_stop[g];
    endsequence
    sequence s_phrase_issued;
      launch_phrase_cmd_start[g] && launch_phrase_cmd_index[g] == $past(st.pend_phrase[g]) && st.kind[g] == K_PHRASE;
    endsequence
    a_queue_drops_ready: assert property (acc_queue[g] |=> !channel_cmd_ready[g])
      else $error("ready stayed high after a queueing command");
    a_stop_frees_channel: assert property (acc_stop[g] |=> channel_cmd_ready[g] && channel_busy_n[g])
      else $error("stopped channel not freed");
    a_clear_repeat_ready: assert property (acc_clr[g] && !st.pend[g] |=> !st.rpt[g] ##0 channel_cmd_ready[g])
      else $error("clear repeat did not restore ready");
    a_volume_code_write: assert property (acc_vol[g] |=> channel_volume[g] == $past(vol_code))
      else $error("channel volume not written");
    a_phrase_start_index: assert property (s_load_phrase |=> s_phrase_issued)
      else $error("queued phrase not started with its index");
    a_silence_unit_load: assert property (st.kind[g] == K_IDLE && st.pend[g] && st.pend_kind[g] == K_SILENCE
                                          && !acc_stop[g] |=> st.kind[g] == K_SILENCE
                                          && st.units[g] == {1'b0, $past(st.pend_len[g])} + 9'd1)
      else $error("silence length not loaded as length plus one");
    a_silence_not_repeated: assert property (st.kind[g] == K_SILENCE && st.units[g] == 9'd1 && st.sub[g] == 18'd0
                                             && !acc_stop[g] |=> st.kind[g] == K_IDLE && !launch_phrase_cmd_start[g])
      else $error("silence segment repeated");
    a_repeat_replays: assert property (st.kind[g] == K_PHRASE && st.rpt[g] && phrase_end[g] && !acc_stop[g]
                                       |=> launch_phrase_cmd_start[g] && st.kind[g] == K_PHRASE)
      else $error("repeat did not replay phrase");
  end

  a_zero_mask_ignored: assert property (zero_mask_cmd |=> launch_phrase_cmd_stop == 4'h0 && $stable(st.rpt)
                                        && $stable(channel_volume))
    else $error("zero mask command had an effect");
  a_power_down_volume: assert property (power_down_req |-> channel_volume == {NUM_CH{VOL_INIT}})
    else $error("power down left a volume set");

endmodule : channel_playback_command_decoder

// ==== core/playback_cmd_pkg.sv ====
/*
  Constants and types shared by the playback command decoder and its serial
  byte receiver. Assumes a 40 MHz system clock and four playback channels.
*/
package playback_cmd_pkg;

  localparam int          NUM_CH              = 4;
  localparam int          CLK_PERIOD_NS       = 25;
  localparam int          SILENCE_UNIT_MS     = 4;
  localparam int          SILENCE_UNIT_CYC    = SILENCE_UNIT_MS * 1000000 / CLK_PERIOD_NS;

  // Command opcodes in the top nibble of the first byte
  localparam logic [3:0]  OP_SELECT           = 4'h3;
  localparam logic [3:0]  OP_LAUNCH           = 4'h4;
  localparam logic [3:0]  OP_START            = 4'h5;
  localparam logic [3:0]  OP_STOP             = 4'h6;
  localparam logic [3:0]  OP_SILENCE          = 4'h7;
  localparam logic [3:0]  OP_SET_REPEAT       = 4'h8;
  localparam logic [3:0]  OP_CLEAR_REPEAT     = 4'h9;
  localparam logic [3:0]  OP_VOLUME           = 4'ha;
  localparam logic [7:0]  POWER_DOWN_BYTE     = 8'h20;

  // Field positions
  localparam int          OP_LSB              = 4;
  localparam int          PHRASE_HI_LSB       = 2;
  localparam int          VOL_LOW_LSB         = 5;
  localparam logic [6:0]  VOL_INIT            = 7'h00;
  localparam logic [7:0]  SILENCE_MIN_LEN     = 8'h04;

  // Register map (byte addresses)
  localparam logic [7:0]  REG_STATUS          = 8'h00;
  localparam logic [7:0]  REG_CONTROL         = 8'h04;
  localparam logic [7:0]  REG_VOLUME          = 8'h08;
  localparam int          STATUS_BUSY_LSB     = 4;
  localparam int          STATUS_RPT_LSB      = 8;
  localparam int          CONTROL_HOLD_BIT    = 0;
  localparam logic [1:0]  RESP_OKAY           = 2'b00;
  localparam logic [1:0]  RESP_SLVERR         = 2'b10;

  typedef enum logic [1:0] {
    K_IDLE    = 2'b00,
    K_PHRASE  = 2'b01,
    K_SILENCE = 2'b10
  } chan_kind_t;

endpackage : playback_cmd_pkg

// ==== core/serial_byte_rx.sv ====
/*
  Serial command byte receiver: samples clock, select and data pins with the
  system clock, shifts data MSB first on rising serial clock edges.
  Assumes the serial clock is slower than a quarter of the system clock.
*/
`timescale 1ns/1ps
module serial_byte_rx (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       sclk_pin,
  input  wire logic       cs_n_pin,
  input  wire logic       si_pin,
  output logic            byte_valid,
  output logic [7:0]      byte_data,
  output logic            frame_start
);
  import playback_cmd_pkg::*;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic       sclk_d;
    logic       cs_d;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic       valid;
    logic [7:0] data;
    logic       fstart;
  } rx_state_t;

  rx_state_t st;
  rx_state_t next_st;

  always_comb begin
    next_st        = st;
    next_st.s1     = {sclk_pin, cs_n_pin, si_pin};
    next_st.s2     = st.s1;
    next_st.sclk_d = st.s2[2];
    next_st.cs_d   = st.s2[1];
    next_st.valid  = 1'b0;
    next_st.fstart = st.cs_d & ~st.s2[1];
    if (st.s2[1]) begin
      next_st.cnt = 3'd0;
    end else if (st.s2[2] & ~st.sclk_d) begin
      next_st.sh  = {st.sh[6:0], st.s2[0]};
      next_st.cnt = st.cnt + 3'd1;
      if (st.cnt == 3'd7) begin
        next_st.valid = 1'b1;
        next_st.data  = {st.sh[6:0], st.s2[0]};
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign byte_valid  = st.valid;
  assign byte_data   = st.data;
  assign frame_start = st.fstart;

endmodule : serial_byte_rx

// ==== tb/cmd_host.sv ====
/*
  Serial host model that sends one- or two-byte command frames.
  Assumes the bench clock is 40 MHz, so sclk runs at 200 ns and idles low.
*/
`timescale 1ns/1ps
module cmd_host (
  input  wire logic clk,
  output logic      sclk,
  output logic      cs_n,
  output logic      si
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end
  task automatic send(input logic [7:0] b0, input logic [7:0] b1, input bit two);
    logic [15:0] w;
    int          n;
    w = {b0, b1};
    n = two ? 16 : 8;
    @(posedge clk) cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      si <= w[15-i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    si   <= ~si;
    repeat (8) @(posedge clk);
  endtask : send
endmodule : cmd_host

// ==== tb/tb_channel_playback_command_decoder.sv ====
/*
  Self-checking bench for the playback command decoder.
  Assumes cmd_host drives the serial pins and the bench plays the datapath.
*/
`timescale 1ns/1ps
module tb_channel_playback_command_decoder;
  import playback_cmd_pkg::*;
  localparam int   UNIT = 8;
  logic            clk = 1'b0;
  logic            rstn = 1'b0;
  logic [3:0]      pend = 4'h0;
  logic [3:0]      rdy, bsy_n, pst, psp;
  logic [3:0][9:0] pidx;
  logic [3:0][6:0] vol;
  logic            sclk, cs_n, si, awr, wr, bv, arr, rv;
  logic            awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [7:0]      awa = 8'h00, ara = 8'h00;
  logic [31:0]     wd = 32'h0, rd;
  logic [1:0]      bresp, rresp;
  logic            pdr;
  int              starts[4], stops[4], lowcnt, pds, mismatches, checks;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    for (int c = 0; c < 4; c++) begin
      if (pst[c] === 1'b1) starts[c]++;
      if (psp[c] === 1'b1) stops[c]++;
    end
    if (bsy_n[1] === 1'b0) lowcnt++;
    if (pdr === 1'b1) pds++;
  end
  cmd_host host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .si(si));
  channel_playback_command_decoder #(.SILENCE_UNIT_CYCLES(18'(UNIT))) DUT (
    .clk(clk), .rstn(rstn), .cmd_sclk(sclk), .cmd_cs_n(cs_n), .cmd_si(si), .phrase_end(pend),
    .channel_cmd_ready(rdy), .channel_busy_n(bsy_n), .launch_phrase_cmd_start(pst), .launch_phrase_cmd_stop(psp),
    .launch_phrase_cmd_index(pidx), .channel_volume(vol), .power_down_req(pdr),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task endp(input int ch);
    @(posedge clk) pend <= 4'(1 << ch);
    @(posedge clk) pend <= 4'h0;
    tick(3);
  endtask : endp
  task launch(input logic [1:0] ch, input logic [9:0] ph);
    host.send({OP_LAUNCH, ph[9:8], ch}, ph[7:0], 1'b1);
  endtask : launch
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    @(posedge clk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    do begin
      @(negedge clk);
      ta = awv && (awr === 1'b1);
      tw = wv && (wr === 1'b1);
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!((ta || !awv) && (tw || !wv)));
    do @(negedge clk); while (bv !== 1'b1);
    check(32'(bresp), 32'(er));
    @(posedge clk) br <= 1'b0;
  endtask : axi_wr
  task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    do @(negedge clk); while (arr !== 1'b1);
    @(posedge clk) arv <= 1'b0;
    do @(negedge clk); while (rv !== 1'b1);
    check(rd, ed);
    check(32'(rresp), 32'(er));
    @(posedge clk) rr <= 1'b0;
  endtask : axi_rd
  task t_launch(input logic [1:0] ch, input logic [9:0] ph);
    int s;
    s = starts[ch];
    check(32'(vol), 32'h0);
    check(32'(rdy[ch]), 32'h1);
    launch(ch, ph);
    check(starts[ch], s + 1);
    check(32'(pidx[ch]), 32'(ph));
    check(32'(bsy_n[ch]), 32'h0);
    endp(ch);
    check(32'(bsy_n[ch]), 32'h1);
    $display("test launch done");
  endtask : t_launch
  task t_start;
    int s;
    s = starts[2];
    host.send({OP_SELECT, 4'b1010}, 8'haa, 1'b1);
    host.send({OP_START, 4'h0}, 8'h00, 1'b0);
    check(starts[2], s);
    host.send({OP_START, 4'h4}, 8'h00, 1'b0);
    check(starts[2], s + 1);
    check(32'(pidx[2]), 32'h2aa);
    endp(2);
    s = stops[0];
    launch(2'd0, 10'h007);
    host.send({OP_STOP, 4'h1}, 8'h00, 1'b0);
    if (bsy_n[0] !== 1'b1) host.send({OP_STOP, 4'h1}, 8'h00, 1'b0);
    check(stops[0], s + 1);
    check(32'({rdy[0], bsy_n[0]}), 32'h3);
    $display("test start and stop done");
  endtask : t_start
  task t_silence;
    int s, l;
    host.send({OP_SET_REPEAT, 4'h2}, 8'h00, 1'b0);
    s = starts[1];
    l = lowcnt;
    host.send({OP_SILENCE, 4'h2}, SILENCE_MIN_LEN, 1'b1);
    for (int i = 0; i < 400 && bsy_n[1] !== 1'b1; i++) @(posedge clk);
    tick(2);
    check(lowcnt - l, (int'(SILENCE_MIN_LEN) + 1) * UNIT + 1);
    check(starts[1], s);
    host.send({OP_CLEAR_REPEAT, 4'h2}, 8'h00, 1'b0);
    $display("test silence done");
  endtask : t_silence
  task t_repeat;
    int s;
    host.send({OP_SET_REPEAT, 4'h8}, 8'h00, 1'b0);
    s = starts[3];
    launch(2'd3, 10'h012);
    check(32'(rdy[3]), 32'h0);
    endp(3);
    check(starts[3], s + 2);
    host.send({OP_VOLUME, 4'h8}, 8'h20, 1'b1);
    check(32'(vol[3]), 32'h01);
    host.send({OP_CLEAR_REPEAT, 4'h8}, 8'h00, 1'b0);
    check(32'(rdy[3]), 32'h1);
    endp(3);
    check(starts[3], s + 2);
    check(32'(bsy_n[3]), 32'h1);
    $display("test repeat done");
  endtask : t_repeat
  task t_volume;
    int p;
    p = pds;
    launch(2'd0, 10'h001);
    host.send({OP_VOLUME, 4'h5}, 8'h43, 1'b1);
    check(32'(vol), 32'h0023800e);
    host.send({OP_VOLUME, 4'h2}, 8'h1f, 1'b1);
    check(32'(vol[1]), 32'h7c);
    host.send(POWER_DOWN_BYTE, 8'h00, 1'b0);
    check(32'(vol[0]), 32'h0e);
    check(pds, p);
    endp(0);
    host.send(POWER_DOWN_BYTE, 8'h00, 1'b0);
    check(32'(vol), 32'h0);
    check(pds, p + 1);
    $display("test volume done");
  endtask : t_volume
  task t_axi;
    int s;
    axi_rd(REG_STATUS, 32'h0ff, RESP_OKAY);
    axi_wr(REG_CONTROL, 32'h1, RESP_OKAY);
    axi_rd(REG_CONTROL, 32'h1, RESP_OKAY);
    s = starts[0];
    launch(2'd0, 10'h002);
    check(starts[0], s);
    axi_wr(REG_CONTROL, 32'h0, RESP_OKAY);
    axi_wr(8'h40, 32'h1, RESP_SLVERR);
    axi_rd(8'h40, 32'h0, RESP_SLVERR);
    host.send({OP_VOLUME, 4'hf}, 8'h1f, 1'b1);
    axi_rd(REG_VOLUME, 32'h7c7c7c7c, RESP_OKAY);
    $display("test register bus done");
  endtask : t_axi
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  initial begin
    tick(8);
    rstn <= 1'b1;
    tick(5);
    t_launch(2'd1, 10'h105);
    t_launch(2'd3, 10'h3ff);
    t_start;
    t_silence;
    t_repeat;
    t_volume;
    t_axi;
    print_verdict;
  end
  // About fifteen times the expected run of some 2600 cycles
  initial begin
    #1000000;
    mismatches++;
    print_verdict;
  end
endmodule : tb_channel_playback_command_decoder
